// file: pcm_port_mux.sv
// Notes on behaviour
// - pin6 driven by async transmit instead of the latch when that function is chosen, dir 0.
// - sync mode: pin6 outputs the sync clock with dir 0, and feeds the clock input with dir 1.
// - pin7 outputs sync data with dir 0 over the latch, and is data input with dir 1.
// - pin7 with dir 1 feeds the async receive input of the serial unit.
// - pin7 carries the spi serial output of sync port one when dir is 0.
// - as parallel address bit4, pin7 direction comes from the parallel port, dir bit ignored.
// - as parallel address bit5, pin6 is input with dir 1 and drives the address with dir 0.
// - pin6 is remap pin 17: input with dir 1, output with dir 0.
// - pin7 is remap pin 18: input with dir 1, output with dir 0.
// - parallel address functions exist only when the large-package parameter is set.
// - pins 4 and 5 have no direction bits and are inputs only.
// - direction reads return stored bits even under peripheral override.
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pcm_defines.svh"
module pcm_port_mux
#(
    parameter bit LARGE_PKG = 1'b1,
    parameter int PORT_W    = 8
) (
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    // ahb-lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // port pins
    input  wire logic [7:0]  pin_in_i,
    output logic      [7:0]  pin_out_o,
    output logic      [7:0]  pin_oe_o,
    // serial unit
    input  wire logic        async_transmit_out_i,
    output logic             async_receive_in_o,
    input  wire logic        sync_serial_clock_out_i,
    output logic             sync_serial_clock_in_o,
    input  wire logic        sync_serial_data_out_i,
    output logic             sync_serial_data_in_o,
    // sync serial port one
    input  wire logic        spi_serial_out_i,
    // capture/compare units 9 and 10
    input  wire logic        capcomp_unit9_out_i,
    input  wire logic        capcomp_unit10_out_i,
    output logic             capcomp_unit9_in_o,
    output logic             capcomp_unit10_in_o,
    // parallel master port
    input  wire logic        parallel_addr_bit5_out_i,
    output logic             parallel_addr_bit5_in_o,
    input  wire logic        parallel_addr_bit4_out_i,
    input  wire logic        parallel_addr_bit4_oe_i,
    output logic             parallel_addr_bit4_in_o,
    // remappable peripheral pins
    input  wire logic        remap_pin_17_out_i,
    input  wire logic        remap_pin_18_out_i,
    output logic             remap_pin_17_in_o,
    output logic             remap_pin_18_in_o
);
    import pcm_pkg::*;

    // refused at elaboration: the pin map is fixed to an 8-bit port
    if (PORT_W != 8)
    begin : g_bad_width
        $error("pcm_port_mux serves only an 8-bit port");
    end

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    logic       rst_meta;
    logic       rst_n;
    logic [7:0] pin_sync;
    logic [7:0] port_output_latch;
    logic [7:0] port_direction;
    pcm_fn_t    fn6;
    pcm_fn_t    fn7;
    logic                   dp_write;
    logic [`PCM_ADDR_W-1:0] dp_addr;
    logic [7:0] next_out;
    logic [7:0] next_oe;

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // pin levels arrive asynchronously
    pcm_pin_sync #(
        .WIDTH (8)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n),
        .async_i   (pin_in_i),
        .sync_o    (pin_sync)
    );

    // parallel address function is refused on the small package
    function automatic pcm_fn_t fn_legal(input logic [3:0] code);
        pcm_fn_t f;
        f = pcm_fn_t'(code);
        case (code)
            PCM_FN_GPIO, PCM_FN_CAPCMP, PCM_FN_ATX, PCM_FN_ARX,
            PCM_FN_SYNC, PCM_FN_SPI, PCM_FN_REMAP: f = pcm_fn_t'(code);
            PCM_FN_PADDR: f = LARGE_PKG ? PCM_FN_PADDR : PCM_FN_GPIO;
            default:      f = PCM_FN_GPIO;
        endcase
        return f;
    endfunction : fn_legal

    // bus address phase capture; zero wait states
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dp_write <= 1'b0;
            dp_addr  <= '0;
        end
        else if (hready_i)
        begin
            dp_write <= hsel_i && hwrite_i && (htrans_i == HTRANS_NONSEQ);
            dp_addr  <= haddr_i[`PCM_ADDR_W-1:0];
        end
    end

    // register writes in the data phase
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_output_latch <= `PCM_LATCH_RST;
            port_direction    <= `PCM_DIR_RST;
            fn6               <= PCM_FN_GPIO;
            fn7               <= PCM_FN_GPIO;
        end
        else if (dp_write)
        begin
            case (dp_addr)
                // writing the pin-level register lands in the latch
                `PCM_OFS_PIN_LEVELS, `PCM_OFS_LATCH: port_output_latch <= hwdata_i[7:0];
                `PCM_OFS_DIRECTION:
                    port_direction <= (hwdata_i[7:0] & `PCM_DIR_IMPL_MASK)
                                    | ~`PCM_DIR_IMPL_MASK;
                `PCM_OFS_FUNC_SEL:
                begin
                    fn6 <= fn_legal(hwdata_i[`PCM_SEL6_LSB +: 4]);
                    fn7 <= fn_legal(hwdata_i[`PCM_SEL7_LSB +: 4]);
                end
                default: ;
            endcase
        end
    end

    // read data always valid; unmapped reads give zero
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            hrdata_o <= '0;
        else if (hready_i && hsel_i && !hwrite_i && htrans_i == HTRANS_NONSEQ)
        begin
            case (haddr_i[`PCM_ADDR_W-1:0])
                `PCM_OFS_PIN_LEVELS: hrdata_o <= {24'h0, pin_sync};
                `PCM_OFS_LATCH:      hrdata_o <= {24'h0, port_output_latch};
                `PCM_OFS_DIRECTION:  hrdata_o <= {24'h0, port_direction};
                `PCM_OFS_FUNC_SEL:   hrdata_o <= {24'h0, fn7, fn6};
                `PCM_OFS_PKG_INFO:   hrdata_o <= {31'h0, LARGE_PKG};
                default:             hrdata_o <= '0;
            endcase
        end
    end

    // always ready, always okay
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
        else
        begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    // pin drive selection
    always_comb
    begin
        // lower pins: plain gpio; pins 4 and 5 never drive
        next_out = port_output_latch;
        next_oe  = ~port_direction & `PCM_DIR_IMPL_MASK;
        case (fn6)
            PCM_FN_CAPCMP: next_out[`PCM_PIN6] = capcomp_unit9_out_i;
            PCM_FN_PADDR:  next_out[`PCM_PIN6] = parallel_addr_bit5_out_i;
            PCM_FN_ATX:    next_out[`PCM_PIN6] = async_transmit_out_i;
            PCM_FN_SYNC:   next_out[`PCM_PIN6] = sync_serial_clock_out_i;
            PCM_FN_REMAP:  next_out[`PCM_PIN6] = remap_pin_17_out_i;
            default:       next_out[`PCM_PIN6] = port_output_latch[`PCM_PIN6];
        endcase
        case (fn7)
            PCM_FN_CAPCMP: next_out[`PCM_PIN7] = capcomp_unit10_out_i;
            PCM_FN_PADDR:
            begin
                // direction owned by the parallel port
                next_out[`PCM_PIN7] = parallel_addr_bit4_out_i;
                next_oe[`PCM_PIN7]  = parallel_addr_bit4_oe_i;
            end
            PCM_FN_SYNC:   next_out[`PCM_PIN7] = sync_serial_data_out_i;
            PCM_FN_SPI:    next_out[`PCM_PIN7] = spi_serial_out_i;
            PCM_FN_REMAP:  next_out[`PCM_PIN7] = remap_pin_18_out_i;
            default:       next_out[`PCM_PIN7] = port_output_latch[`PCM_PIN7];
        endcase
    end

    // pins registered so outputs come from flops
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_out_o <= '0;
            pin_oe_o  <= '0;
        end
        else
        begin
            pin_out_o <= next_out;
            pin_oe_o  <= next_oe;
        end
    end

    // peripheral inputs: only fed while the pin is an input of that function
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            async_receive_in_o      <= 1'b1;
            sync_serial_clock_in_o  <= 1'b0;
            sync_serial_data_in_o   <= 1'b0;
            capcomp_unit9_in_o      <= 1'b0;
            capcomp_unit10_in_o     <= 1'b0;
            parallel_addr_bit5_in_o <= 1'b0;
            parallel_addr_bit4_in_o <= 1'b0;
            remap_pin_17_in_o       <= 1'b0;
            remap_pin_18_in_o       <= 1'b0;
        end
        else
        begin
            // idle-high receive line when not selected
            async_receive_in_o <= (fn7 == PCM_FN_ARX && port_direction[`PCM_PIN7])
                                ? pin_sync[`PCM_PIN7] : 1'b1;
            sync_serial_clock_in_o <= (fn6 == PCM_FN_SYNC && port_direction[`PCM_PIN6])
                                    & pin_sync[`PCM_PIN6];
            sync_serial_data_in_o <= (fn7 == PCM_FN_SYNC && port_direction[`PCM_PIN7])
                                   & pin_sync[`PCM_PIN7];
            capcomp_unit9_in_o <= (fn6 == PCM_FN_CAPCMP && port_direction[`PCM_PIN6])
                                & pin_sync[`PCM_PIN6];
            capcomp_unit10_in_o <= (fn7 == PCM_FN_CAPCMP && port_direction[`PCM_PIN7])
                                 & pin_sync[`PCM_PIN7];
            parallel_addr_bit5_in_o <= (fn6 == PCM_FN_PADDR && port_direction[`PCM_PIN6])
                                     & pin_sync[`PCM_PIN6];
            parallel_addr_bit4_in_o <= (fn7 == PCM_FN_PADDR && !parallel_addr_bit4_oe_i)
                                     & pin_sync[`PCM_PIN7];
            remap_pin_17_in_o <= (fn6 == PCM_FN_REMAP && port_direction[`PCM_PIN6])
                               & pin_sync[`PCM_PIN6];
            remap_pin_18_in_o <= (fn7 == PCM_FN_REMAP && port_direction[`PCM_PIN7])
                               & pin_sync[`PCM_PIN7];
        end
    end
endmodule : pcm_port_mux
`default_nettype wire

// file: pcm_defines.svh
`ifndef PCM_DEFINES_SVH
`define PCM_DEFINES_SVH

// register byte offsets on the bus
`define PCM_OFS_PIN_LEVELS   8'h00
`define PCM_OFS_LATCH        8'h04
`define PCM_OFS_DIRECTION    8'h08
`define PCM_OFS_FUNC_SEL     8'h0c
`define PCM_OFS_PKG_INFO     8'h10

// reset values
`define PCM_LATCH_RST        8'h00
`define PCM_DIR_RST          8'hff
`define PCM_FUNC_RST         8'h00

// bit positions of the port
`define PCM_PIN6             3'd6
`define PCM_PIN7             3'd7
// pins 4 and 5 have no direction bits
`define PCM_DIR_IMPL_MASK    8'hcf

// function select fields: pin6 in [3:0], pin7 in [7:4]
`define PCM_SEL6_LSB         3'd0
`define PCM_SEL7_LSB         3'd4

// register address width
`define PCM_ADDR_W           8

`endif

// file: pcm_pkg.sv
`default_nettype none
package pcm_pkg;
    // function that owns an upper pin
    typedef enum logic [3:0] {
        PCM_FN_GPIO   = 4'h0,
        PCM_FN_CAPCMP = 4'h1,
        PCM_FN_PADDR  = 4'h2,
        PCM_FN_ATX    = 4'h3,
        PCM_FN_ARX    = 4'h4,
        PCM_FN_SYNC   = 4'h5,
        PCM_FN_SPI    = 4'h6,
        PCM_FN_REMAP  = 4'h7
    } pcm_fn_t;
endpackage : pcm_pkg
`default_nettype wire

// file: pcm_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage pin synchroniser; a change is taken once stages two and three agree
module pcm_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // shift chain; stage1 only feeds stage2
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end
        else
        begin
            stage1 <= async_i;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // accept per bit only when the last two stages agree
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            sync_o <= '0;
        else
            for (int i = 0; i < WIDTH; i++)
                if (stage2[i] == stage3[i])
                    sync_o[i] <= stage3[i];
    end
endmodule : pcm_pin_sync
`default_nettype wire

// file: pcm_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pcm_chk (
    input wire logic        ref_clk_i,
    input wire logic        nrst_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic [7:0]  pin_in_i,
    input wire logic [7:0]  pin_out_o,
    input wire logic [7:0]  pin_oe_o,
    input wire logic        async_transmit_out_i,
    input wire logic        async_receive_in_o,
    input wire logic        sync_serial_clock_in_o,
    input wire logic        spi_serial_out_i,
    input wire logic        parallel_addr_bit4_oe_i
);
    logic [7:0] lt, dr, fs, ad;
    logic       wp, rp, go;
    assign go = hsel_i && hready_i && htrans_i == 2'b10;
    // bus-side copy of latch, direction and select; bits 4 and 5 read as 1
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            {lt, dr, fs, ad, wp, rp} <= {24'h00ff00, 8'h00, 2'b00};
        end
        else
        begin
            wp <= go && hwrite_i;
            rp <= go && !hwrite_i;
            ad <= haddr_i[7:0];
            if (wp && ad[7:3] == 5'h00)
                lt <= hwdata_i[7:0];
            if (wp && ad == 8'h08)
                dr <= hwdata_i[7:0] | 8'h30;
            if (wp && ad == 8'h0c)
                fs <= hwdata_i[7:0];
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    property p_atx;
        fs[3:0] == 4'h3 && !dr[6] |=> pin_oe_o[6] && pin_out_o[6] == $past(async_transmit_out_i);
    endproperty
    a_atx: assert property (p_atx) else $error("pin6 misses async transmit");
    property p_sclk_in;
        (fs[3:0] == 4'h5 && dr[6] && $stable(pin_in_i[6]))[*7] |-> sync_serial_clock_in_o == pin_in_i[6];
    endproperty
    a_sclk_in: assert property (p_sclk_in) else $error("clock input not from pin6");
    property p_arx;
        (fs[7:4] == 4'h4 && dr[7] && $stable(pin_in_i[7]))[*7] |-> async_receive_in_o == pin_in_i[7];
    endproperty
    a_arx: assert property (p_arx) else $error("receive input not from pin7");
    property p_spi;
        fs[7:4] == 4'h6 && !dr[7] |=> pin_oe_o[7] && pin_out_o[7] == $past(spi_serial_out_i);
    endproperty
    a_spi: assert property (p_spi) else $error("pin7 misses spi output");
    property p_pa4;
        fs[7:4] == 4'h2 |=> pin_oe_o[7] == $past(parallel_addr_bit4_oe_i);
    endproperty
    a_pa4: assert property (p_pa4) else $error("pin7 enable not from parallel port");
    property p_rmp;
        fs[3:0] == 4'h7 |=> pin_oe_o[6] == !$past(dr[6]);
    endproperty
    a_rmp: assert property (p_rmp) else $error("remap pin6 enable wrong");
    property p_in45;
        pin_oe_o[5:4] == 2'b00;
    endproperty
    a_in45: assert property (p_in45) else $error("pin4 or pin5 driven");
    property p_dir_rd;
        rp && ad == 8'h08 |-> hrdata_o[7:0] == dr;
    endproperty
    a_dir_rd: assert property (p_dir_rd) else $error("direction read wrong");
    property p_gpio;
        fs[7:4] == 4'h0 |=> pin_oe_o[7] == !$past(dr[7]) && (!pin_oe_o[7] || pin_out_o[7] == $past(lt[7]));
    endproperty
    a_gpio: assert property (p_gpio) else $error("pin7 plain port wrong");
    c_dir_rd: cover property (rp && ad == 8'h08);
    c_pa: cover property (fs == 8'h22 && !dr[7]);
    c_arx: cover property (fs[7:4] == 4'h4 && dr[7]);
endmodule : pcm_chk
bind pcm_port_mux pcm_chk u_chk (
    .ref_clk_i, .nrst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i,
    .hrdata_o, .pin_in_i, .pin_out_o, .pin_oe_o, .async_transmit_out_i, .async_receive_in_o,
    .sync_serial_clock_in_o, .spi_serial_out_i, .parallel_addr_bit4_oe_i
);
`default_nettype wire

// file: pcm_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcm_far_model (
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    input  wire logic [7:0]  pin_out_i,
    input  wire logic [7:0]  pin_oe_i,
    input  wire logic [7:0]  ext_en_i,
    input  wire logic [7:0]  ext_val_i,
    input  wire logic [10:0] per_set_i,
    input  wire logic        tgl_i,
    output logic      [7:0]  pin_lvl_o,
    output logic      [10:0] per_o
);
    logic [7:0]  last;
    logic [10:0] cnt;
    // free counter gives busy peripheral traffic
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt  <= 11'h000;
            last <= 8'h00;
        end
        else
        begin
            cnt  <= cnt + 11'h001;
            last <= pin_lvl_o;
        end
    end
    // driver wins, then the board; a floating pin flips so it never looks held
    always_comb
        for (int i = 0; i < 8; i++)
            pin_lvl_o[i] = pin_oe_i[i] ? pin_out_i[i] : (ext_en_i[i] ? ext_val_i[i] : ~last[i]);
    assign per_o = tgl_i ? cnt : per_set_i;
endmodule : pcm_far_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        ref_clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        hsel_i = 1'b0;
    logic        hwrite_i = 1'b0;
    logic        tgl = 1'b0;
    logic [1:0]  htrans_i = 2'b00;
    logic [2:0]  hsize_i = 3'b010;
    logic [31:0] haddr_i = 32'h0;
    logic [31:0] hwdata_i = 32'h0;
    logic [31:0] hrdata_o;
    logic        hreadyout_o;
    logic        hresp_o;
    logic [7:0]  pin_in_i, pin_out_o, pin_oe_o;
    logic [7:0]  ext_en = 8'h00;
    logic [7:0]  ext_val = 8'h00;
    logic [10:0] per_set = 11'h000;
    logic [10:0] per;
    wire  logic [8:0] ins;
    int          errors = 0;
    int          total_checks = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    pcm_port_mux uut (
        .ref_clk_i, .nrst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
        .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .pin_in_i, .pin_out_o,
        .pin_oe_o, .async_transmit_out_i(per[0]), .async_receive_in_o(ins[0]),
        .sync_serial_clock_out_i(per[1]), .sync_serial_clock_in_o(ins[1]),
        .sync_serial_data_out_i(per[2]), .sync_serial_data_in_o(ins[2]),
        .spi_serial_out_i(per[3]), .capcomp_unit9_out_i(per[4]), .capcomp_unit10_out_i(per[5]),
        .capcomp_unit9_in_o(ins[3]), .capcomp_unit10_in_o(ins[4]),
        .parallel_addr_bit5_out_i(per[6]), .parallel_addr_bit5_in_o(ins[5]),
        .parallel_addr_bit4_out_i(per[7]), .parallel_addr_bit4_oe_i(per[8]),
        .parallel_addr_bit4_in_o(ins[6]), .remap_pin_17_out_i(per[9]),
        .remap_pin_18_out_i(per[10]), .remap_pin_17_in_o(ins[7]), .remap_pin_18_in_o(ins[8])
    );
    pcm_far_model far (
        .ref_clk_i, .nrst_i, .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .per_set_i(per_set), .tgl_i(tgl), .pin_lvl_o(pin_in_i), .per_o(per)
    );
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one single word transfer; waits on hready, bounded
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        hsel_i   <= 1'b1;
        htrans_i <= 2'b10;
        hwrite_i <= w;
        haddr_i  <= {24'h0, a};
        do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1 && n++ < 50);
        htrans_i <= 2'b00;
        hsel_i   <= 1'b0;
        hwdata_i <= d;
        do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1 && n++ < 50);
        r = hrdata_o;
        if (n > 49)
        begin
            errors++;
            end_sim;
        end
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, {24'h0, d}, r);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, {24'h0, e});
    endtask : rd
    task automatic do_reset(input int n);
        nrst_i <= 1'b0;
        repeat (n) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
    endtask : do_reset
    task automatic t_regs;
        chk({24'h0, pin_oe_o}, 32'h0);
        rd(8'h04, 8'h00);
        rd(8'h08, 8'hff);
        rd(8'h0c, 8'h00);
        rd(8'h10, 8'h01);
        chk({31'h0, hresp_o}, 32'h0);
        wr(8'h14, 8'hff);
        rd(8'h14, 8'h00);
    endtask : t_regs
    task automatic t_gpio;
        ext_en  <= 8'hff;
        ext_val <= 8'h15;
        wr(8'h04, 8'h80);
        wr(8'h08, 8'h00);
        repeat (8) @(posedge ref_clk_i);
        chk({16'h0, pin_oe_o, pin_out_o & 8'hc0}, 32'hcf80);
        rd(8'h08, 8'h30);
        rd(8'h00, 8'h90);
        wr(8'h08, 8'hff);
        repeat (8) @(posedge ref_clk_i);
        rd(8'h00, 8'h15);
    endtask : t_gpio
    // each pin function driven out, latch set against it, other lines inverted
    task automatic t_out;
        logic [7:0]  fsv [5] = '{8'h11, 8'h22, 8'h53, 8'h65, 8'h77};
        int          i6 [5] = '{4, 6, 0, 1, 9};
        int          i7 [5] = '{5, 7, 2, 3, 10};
        logic [10:0] m;
        wr(8'h08, 8'h00);
        for (int k = 0; k < 5; k++)
        begin
            wr(8'h0c, fsv[k]);
            m = (11'h1 << i6[k]) | (11'h1 << i7[k]);
            for (int v = 0; v < 2; v++)
            begin
                wr(8'h04, v[0] ? 8'h00 : 8'hff);
                per_set <= v[0] ? m : ~m;
                repeat (3) @(posedge ref_clk_i);
                chk({28'h0, pin_oe_o[7:6], pin_out_o[7:6]},
                    {28'h0, k == 1 ? ~v[0] : 1'b1, 1'b1, v[0], v[0]});
            end
        end
        rd(8'h08, 8'h30);
        wr(8'h0c, 8'h63);
        tgl <= 1'b1;
        repeat (40) @(posedge ref_clk_i);
        tgl <= 1'b0;
    endtask : t_out
    // pins as inputs feed each selected peripheral
    task automatic t_in;
        logic [7:0] fsv [5] = '{8'h11, 8'h22, 8'h45, 8'h55, 8'h77};
        logic [1:0] g;
        wr(8'h08, 8'hff);
        per_set <= 11'h000;
        for (int k = 0; k < 5; k++)
        begin
            wr(8'h0c, fsv[k]);
            for (int v = 0; v < 2; v++)
            begin
                ext_val <= {v[0], ~v[0], 6'h15};
                repeat (8) @(posedge ref_clk_i);
                case (k)
                    0: g = {ins[3], ins[4]};
                    1: g = {ins[5], ins[6]};
                    2: g = {ins[1], ins[0]};
                    3: g = {ins[1], ins[2]};
                    default: g = {ins[7], ins[8]};
                endcase
                chk({30'h0, g}, {30'h0, ~v[0], v[0]});
            end
        end
    endtask : t_in
    initial
    begin
        do_reset(16);
        t_regs;
        t_gpio;
        t_out;
        t_in;
        do_reset(3);
        rd(8'h08, 8'hff);
        end_sim;
    end
endmodule : tb_top
`default_nettype wire
